// ==== rtl/sdim_pkg.sv ====
/*
 * sdim_pkg: constants, states and carriers of the sdram init host.
 * assumes the sdram controller registers sit at DEV_REG_BASE on a
 * simple write port that shares REF_CLK.
 */
package sdim_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PAUSE_NS      = 200000;
  localparam int unsigned PAUSE_CYC     = (PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] PAUSE_LAST    = 12'(PAUSE_CYC - 1);
  localparam logic [2:0]  REF_LAST      = 3'h7;

  // ----------------------------------------------------------------
  // sdram controller side
  // ----------------------------------------------------------------
  localparam logic [31:0] DEV_REG_BASE  = 32'h0001_0000;
  localparam logic [31:0] DEV_OFF_MODE  = 32'h0000_0000;
  localparam logic [31:0] DEV_OFF_TR    = 32'h0000_0004;
  localparam logic [31:0] DEV_OFF_CFG   = 32'h0000_0008;
  localparam logic [31:0] DEV_OFF_LP    = 32'h0000_000c;
  localparam logic [31:0] DEV_OFF_MDEV  = 32'h0000_0010;
  localparam logic [2:0]  MODE_NORMAL   = 3'h0;
  localparam logic [2:0]  MODE_NOP      = 3'h1;
  localparam logic [2:0]  MODE_PRECH    = 3'h2;
  localparam logic [2:0]  MODE_MRS      = 3'h3;
  localparam logic [2:0]  MODE_REFRESH  = 3'h4;
  localparam logic [2:0]  MODE_EMRS     = 3'h5;
  localparam logic [4:0]  BYTE_SEL_BITS = 5'h01;
  localparam logic [4:0]  COL_BITS_MIN  = 5'h08;
  localparam logic [4:0]  ROW_BITS_4K   = 5'h0c;
  localparam logic [4:0]  ROW_BITS_8K   = 5'h0d;

  // ----------------------------------------------------------------
  // own register map
  // ----------------------------------------------------------------
  localparam logic [2:0]  IDX_CTRL      = 3'h0;
  localparam logic [2:0]  IDX_STAT      = 3'h1;
  localparam logic [2:0]  IDX_CFG       = 3'h2;
  localparam logic [2:0]  IDX_LP        = 3'h3;
  localparam logic [2:0]  IDX_MDEV      = 3'h4;
  localparam logic [2:0]  IDX_TR        = 3'h5;
  localparam logic [2:0]  IDX_BASE      = 3'h6;
  localparam int unsigned CTRL_START    = 0;
  localparam int unsigned CTRL_MOBILE   = 1;
  localparam int unsigned CTRL_ROW8K    = 2;
  localparam int unsigned CTRL_COL_LSB  = 4;
  localparam int unsigned STAT_BUSY     = 0;
  localparam int unsigned STAT_DONE     = 1;
  localparam int unsigned STAT_ST_LSB   = 8;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [4:0] {
    S_IDLE = 5'h00, S_CFG  = 5'h01, S_LP   = 5'h03, S_MDEV = 5'h02,
    S_WAIT = 5'h06, S_NOPM = 5'h07, S_NOPW = 5'h05, S_PREM = 5'h04,
    S_PREW = 5'h0c, S_REFM = 5'h0d, S_REFW = 5'h0f, S_MRSM = 5'h0e,
    S_MRSW = 5'h0a, S_EMRM = 5'h0b, S_EMRW = 5'h09, S_NRMM = 5'h08,
    S_NRMW = 5'h18, S_TR   = 5'h19, S_DONE = 5'h1b
  } sdim_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } sdim_req_t;

  typedef struct packed {
    logic       mobile;
    logic       row8k;
    logic [1:0] colsel;
  } sdim_geom_t;

endpackage

// ==== rtl/sdim_host.sv ====
/*
 * sdim_host: software-style sequencer that brings up an sdram through
 * the sdram controller's registers and sdram space, ordered over axi4-lite.
 * assumes the controller shares REF_CLK and takes one write per
 * DEV_VALID/DEV_READY handshake.
 */
// Design decisions made here: the register addresses and the AXI4-Lite slave port.

`timescale 1ns/1ps
module sdim_host
  import sdim_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output sdim_req_t        DEV_REQ,
  output logic             DEV_VALID,
  input  wire logic        DEV_READY
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] bank_lsb(input sdim_geom_t g);
    logic [4:0] rows;
    rows = g.row8k ? ROW_BITS_8K : ROW_BITS_4K;
    bank_lsb = BYTE_SEL_BITS + COL_BITS_MIN + {3'h0, g.colsel} + rows;
  endfunction

  function automatic logic [1:0] bank_of(input logic [31:0] a, input logic [4:0] lsb);
    bank_of = 2'(a >> lsb);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction

  function automatic logic map_index_ok(input logic [7:0] a);
    map_index_ok = a[7:5] == 3'h0 && a[4:2] != 3'h7;
  endfunction

  function automatic logic [31:0] mode_word(input logic [2:0] m);
    mode_word = {29'h0, m};
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sdim_state_t state_ff, nxt_state;
  sdim_req_t   nxt_req;
  sdim_geom_t  geom_ff;
  logic [31:0] cfg_ff, lp_ff, mdev_ff, tr_ff, base_ff;
  logic        aw_got_ff, w_got_ff, awbad_ff, bvalid_ff, rvalid_ff;
  logic [2:0]  awidx_ff;
  logic [31:0] wdata_ff, rdata_ff, rd_word;
  logic [3:0]  wstrb_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic        start_ff, done_ff, valid_ff, commit, dev_acc, busy;
  logic [11:0] wait_cnt_ff;
  logic [2:0]  ref_cnt_ff;
  sdim_req_t   req_ff;
  logic [4:0]  lsb;
  logic [31:0] bank_mask;

  assign lsb       = bank_lsb(geom_ff);
  assign bank_mask = 32'h0000_0003 << lsb;
  assign dev_acc   = valid_ff && DEV_READY;
  assign busy      = state_ff != S_IDLE && state_ff != S_DONE;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // one write in flight; the response waits for both address and data
  assign S_AXI_AWREADY = !aw_got_ff && !bvalid_ff;
  assign S_AXI_WREADY  = !w_got_ff && !bvalid_ff;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;
  assign commit        = aw_got_ff && w_got_ff && !bvalid_ff && !awbad_ff;

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      aw_got_ff <= 1'b0;
      awbad_ff  <= 1'b0;
      awidx_ff  <= 3'h0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_ff <= 1'b1;
      awbad_ff  <= !map_index_ok(S_AXI_AWADDR);
      awidx_ff  <= S_AXI_AWADDR[4:2];
    end else if (aw_got_ff && w_got_ff && !bvalid_ff) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      w_got_ff <= 1'b0;
      wdata_ff <= RST_WORD;
      wstrb_ff <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_ff <= 1'b1;
      wdata_ff <= S_AXI_WDATA;
      wstrb_ff <= S_AXI_WSTRB;
    end else if (aw_got_ff && w_got_ff && !bvalid_ff) begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (aw_got_ff && w_got_ff && !bvalid_ff) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= awbad_ff ? RESP_SLVERR : RESP_OKAY;
    end else if (S_AXI_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // own registers
  // ----------------------------------------------------------------
  // setup words are not locked while busy; rewriting them mid-run is
  // the caller's hazard
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      geom_ff <= '0;
      cfg_ff  <= RST_WORD;
      lp_ff   <= RST_WORD;
      mdev_ff <= RST_WORD;
      tr_ff   <= RST_WORD;
      base_ff <= RST_WORD;
    end else if (commit) begin
      case (awidx_ff)
        IDX_CTRL: begin
          if (wstrb_ff[0]) begin
            geom_ff <= {wdata_ff[CTRL_MOBILE], wdata_ff[CTRL_ROW8K],
                        wdata_ff[CTRL_COL_LSB +: 2]};
          end
        end
        IDX_CFG:  cfg_ff  <= merge(cfg_ff, wdata_ff, wstrb_ff);
        IDX_LP:   lp_ff   <= merge(lp_ff, wdata_ff, wstrb_ff);
        IDX_MDEV: mdev_ff <= merge(mdev_ff, wdata_ff, wstrb_ff);
        IDX_TR:   tr_ff   <= merge(tr_ff, wdata_ff, wstrb_ff);
        IDX_BASE: base_ff <= merge(base_ff, wdata_ff, wstrb_ff);
        default: begin
        end
      endcase
    end
  end

  // start while busy is dropped so a run is never restarted half way
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= commit && awidx_ff == IDX_CTRL && wstrb_ff[0]
                  && wdata_ff[CTRL_START] && !busy;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      done_ff <= 1'b0;
    end else if (nxt_state == S_DONE && state_ff != S_DONE) begin
      done_ff <= 1'b1;
    end else if (start_ff) begin
      done_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign S_AXI_ARREADY = !rvalid_ff;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;

  always_comb begin
    rd_word = RST_WORD;
    case (S_AXI_ARADDR[4:2])
      IDX_CTRL: begin
        rd_word[CTRL_MOBILE]       = geom_ff.mobile;
        rd_word[CTRL_ROW8K]        = geom_ff.row8k;
        rd_word[CTRL_COL_LSB +: 2] = geom_ff.colsel;
      end
      IDX_STAT: begin
        rd_word[STAT_BUSY]       = busy;
        rd_word[STAT_DONE]       = done_ff;
        rd_word[STAT_ST_LSB +: 5] = state_ff;
      end
      IDX_CFG:  rd_word = cfg_ff;
      IDX_LP:   rd_word = lp_ff;
      IDX_MDEV: rd_word = mdev_ff;
      IDX_TR:   rd_word = tr_ff;
      IDX_BASE: rd_word = base_ff;
      default:  rd_word = RST_WORD;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= RST_WORD;
      rresp_ff  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= map_index_ok(S_AXI_ARADDR) ? rd_word : RST_WORD;
      rresp_ff  <= map_index_ok(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // init sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: if (start_ff) nxt_state = S_CFG;
      S_CFG:  if (dev_acc) nxt_state = geom_ff.mobile ? S_LP : S_MDEV;
      S_LP:   if (dev_acc) nxt_state = S_MDEV;
      S_MDEV: if (dev_acc) nxt_state = S_WAIT;
      S_WAIT: if (wait_cnt_ff == PAUSE_LAST) nxt_state = S_NOPM;
      S_NOPM: if (dev_acc) nxt_state = S_NOPW;
      S_NOPW: if (dev_acc) nxt_state = S_PREM;
      S_PREM: if (dev_acc) nxt_state = S_PREW;
      S_PREW: if (dev_acc) nxt_state = S_REFM;
      S_REFM: if (dev_acc) nxt_state = S_REFW;
      S_REFW: if (dev_acc && ref_cnt_ff == REF_LAST) nxt_state = S_MRSM;
      S_MRSM: if (dev_acc) nxt_state = S_MRSW;
      S_MRSW: if (dev_acc) nxt_state = geom_ff.mobile ? S_EMRM : S_NRMM;
      S_EMRM: if (dev_acc) nxt_state = S_EMRW;
      S_EMRW: if (dev_acc) nxt_state = S_NRMM;
      S_NRMM: if (dev_acc) nxt_state = S_NRMW;
      S_NRMW: if (dev_acc) nxt_state = S_TR;
      S_TR:   if (dev_acc) nxt_state = S_DONE;
      S_DONE: if (start_ff) nxt_state = S_CFG;
      default: nxt_state = S_IDLE;
    endcase
  end

  // request follows the next state so address and data leave from flops
  always_comb begin
    nxt_req = '0;
    case (nxt_state)
      S_CFG:  nxt_req = {DEV_REG_BASE + DEV_OFF_CFG, cfg_ff};
      S_LP:   nxt_req = {DEV_REG_BASE + DEV_OFF_LP, lp_ff};
      S_MDEV: nxt_req = {DEV_REG_BASE + DEV_OFF_MDEV, mdev_ff};
      S_NOPM: nxt_req = {DEV_REG_BASE + DEV_OFF_MODE, mode_word(MODE_NOP)};
      S_PREM: nxt_req = {DEV_REG_BASE + DEV_OFF_MODE, mode_word(MODE_PRECH)};
      S_REFM: nxt_req = {DEV_REG_BASE + DEV_OFF_MODE, mode_word(MODE_REFRESH)};
      S_MRSM: nxt_req = {DEV_REG_BASE + DEV_OFF_MODE, mode_word(MODE_MRS)};
      S_EMRM: nxt_req = {DEV_REG_BASE + DEV_OFF_MODE, mode_word(MODE_EMRS)};
      S_NRMM: nxt_req = {DEV_REG_BASE + DEV_OFF_MODE, mode_word(MODE_NORMAL)};
      S_TR:   nxt_req = {DEV_REG_BASE + DEV_OFF_TR, tr_ff};
      // sdram-space triggers carry no data; only the command matters
      S_NOPW, S_PREW, S_REFW, S_NRMW: nxt_req = {base_ff, RST_WORD};
      S_MRSW: nxt_req = {base_ff & ~bank_mask, RST_WORD};
      S_EMRW: nxt_req = {(base_ff & ~bank_mask) | (32'h0000_0001 << lsb), RST_WORD};
      default: nxt_req = '0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      state_ff <= S_IDLE;
      req_ff   <= '0;
      valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      req_ff   <= nxt_req;
      valid_ff <= nxt_state != S_IDLE && nxt_state != S_WAIT && nxt_state != S_DONE;
    end
  end

  assign DEV_REQ   = req_ff;
  assign DEV_VALID = valid_ff;

  always_ff @(posedge REF_CLK) begin
    if (!RSTN || state_ff != S_WAIT) begin
      wait_cnt_ff <= 12'h000;
    end else begin
      wait_cnt_ff <= wait_cnt_ff + 12'h001;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN || state_ff != S_REFW) begin
      ref_cnt_ff <= 3'h0;
    end else if (dev_acc) begin
      ref_cnt_ff <= ref_cnt_ff + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_taken(sdim_state_t st);
    state_ff == st && dev_acc;
  endsequence

  chk_cfg_goes_first: assert property (s_taken(S_CFG) |=>
    state_ff == (geom_ff.mobile ? S_LP : S_MDEV)) else $error("config step misordered");
  chk_lp_before_mdev: assert property (s_taken(S_LP) |=> state_ff == S_MDEV
    ##0 DEV_REQ.addr == DEV_REG_BASE + DEV_OFF_MDEV) else $error("low-power step misordered");
  chk_mdev_then_pause: assert property (s_taken(S_MDEV) |=> !DEV_VALID [*8])
    else $error("memory type not followed by pause");
  chk_pause_length: assert property ($rose(state_ff == S_NOPM) |->
    $past(wait_cnt_ff) == PAUSE_LAST) else $error("pause too short");
  chk_nop_mode_word: assert property (state_ff == S_NOPM |-> DEV_VALID
    && DEV_REQ.data == mode_word(MODE_NOP)) else $error("nop mode word wrong");
  chk_prech_after_nop: assert property (s_taken(S_NOPW) |=>
    DEV_REQ.data == mode_word(MODE_PRECH)) else $error("precharge not after nop");
  chk_eight_refresh: assert property ($rose(state_ff == S_MRSM) |->
    $past(ref_cnt_ff) == REF_LAST) else $error("refresh count not eight");
  chk_mrs_bank_zero: assert property (state_ff == S_MRSW |->
    bank_of(DEV_REQ.addr, lsb) == 2'h0) else $error("mrs bank not zero");
  chk_emrs_bank_set: assert property (state_ff == S_EMRW |->
    bank_of(DEV_REQ.addr, lsb) != 2'h0) else $error("emrs bank not set");
  chk_normal_then_tr: assert property (s_taken(S_NRMW) |=> state_ff == S_TR
    ##0 DEV_REQ.addr == DEV_REG_BASE + DEV_OFF_TR) else $error("normal write not followed by timer");
  chk_tr_ends_run: assert property (s_taken(S_TR) |=> !DEV_VALID && done_ff)
    else $error("timer write did not finish run");
  chk_req_held: assert property (DEV_VALID && !DEV_READY |=> DEV_VALID
    && $stable(DEV_REQ)) else $error("request dropped before taken");

endmodule

// ==== tb/sdim_dev_model.sv ====
/*
 * sdim_dev_model: sdram controller seen through its write port.
 * assumes the host clock, sdram space in the upper half of the
 * address map and a 16-bit geometry given by the bench.
 */
`timescale 1ns/1ps
module sdim_dev_model
  import sdim_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire sdim_req_t  req,
  input  wire logic       valid,
  output logic            ready,
  input  wire logic       stall,
  input  wire sdim_geom_t geom
);
  // ------------------------------------------
  // log and state
  // ------------------------------------------
  logic [63:0] log_q[$];
  int          cmd_q[$];
  int          t_q[$];
  int          cyc;
  int          bad;
  int          refr;
  int          lsb;
  logic [2:0]  mode_ff;
  logic [11:0] tr_ff;
  logic [11:0] tmr_ff;
  logic        pend_ff;
  sdim_req_t   held_ff;

  assign ready = !stall;
  // byte select, column, row, then the two bank bits
  assign lsb = 9 + int'(geom.colsel) + (geom.row8k ? 13 : 12);

  // ------------------------------------------
  // accept writes
  // ------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      mode_ff <= 3'h0;
      tr_ff <= 12'h000;
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
      if (valid && ready) begin
        log_q.push_back(req);
        t_q.push_back(cyc);
        if (req.addr == DEV_REG_BASE + DEV_OFF_MODE) begin
          mode_ff <= req.data[2:0];
        end else if (req.addr == DEV_REG_BASE + DEV_OFF_TR) begin
          tr_ff <= req.data[11:0];
        end else if (req.addr[31]) begin
          cmd_q.push_back(mode_ff * 4 + req.addr[lsb +: 2]);
        end
      end
    end
  end

  // ------------------------------------------
  // stalled request must neither move nor vanish
  // ------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      pend_ff <= 1'b0;
    end else begin
      if (pend_ff && (!valid || req !== held_ff)) bad <= bad + 1;
      pend_ff <= valid && !ready;
      held_ff <= req;
    end
  end

  // ------------------------------------------
  // refresh timer, idle until a count is set
  // ------------------------------------------
  always @(posedge clk) begin
    if (!rstn || tr_ff == 12'h000) begin
      tmr_ff <= 12'h000;
    end else if (tmr_ff == 12'h000) begin
      tmr_ff <= tr_ff;
      refr <= refr + 1;
    end else begin
      tmr_ff <= tmr_ff - 12'h001;
    end
  end
endmodule

// ==== tb/testbench.sv ====
/*
 * testbench: axi4-lite master for sdim_host; reset values, register
 * access, then two bring-ups compared with a reference write list.
 * assumes sdim_pkg, sdim_host and sdim_dev_model are compiled first.
 */
`timescale 1ns/1ps
module testbench
  import sdim_pkg::*;
;
  // ------------------------------------------
  // signals
  // ------------------------------------------
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        stall = 1'b0;
  logic        stall_en = 1'b0;
  sdim_geom_t  geom = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, dev_valid, dev_ready;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, sr, e_base;
  logic [31:0] rng = 32'h32;
  sdim_req_t   dev_req;
  logic [63:0] exp_q[$];
  int          exp_cmd[$];
  int          e_lsb;
  int          bad_count = 0;
  int          checks_done = 0;

  initial begin
    forever #25 clk = ~clk;
  end

  sdim_host dut (
    .REF_CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .DEV_REQ(dev_req), .DEV_VALID(dev_valid), .DEV_READY(dev_ready));

  sdim_dev_model dev (.clk(clk), .rstn(rstn), .req(dev_req), .valid(dev_valid),
                      .ready(dev_ready), .stall(stall), .geom(geom));

  // ------------------------------------------
  // helpers
  // ------------------------------------------
  function logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // random stalls so both back-to-back and slow takes occur
  always @(posedge clk) begin
    sr = rnd();
    stall <= stall_en & sr[0];
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (aw_ok && w_ok) bready <= 1'b1;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        rready <= 1'b1;
      end
    end
  endtask

  task automatic wr_ok(input logic [2:0] idx, input logic [31:0] d);
    logic [1:0] r;
    axi_wr({3'h0, idx, 2'h0}, d, 4'hf, r);
    check(r, RESP_OKAY, "bresp");
  endtask

  task automatic rd_reg(input logic [2:0] idx, output logic [31:0] d);
    logic [1:0] r;
    axi_rd({3'h0, idx, 2'h0}, d, r);
    check(r, RESP_OKAY, "rresp");
  endtask

  task automatic push_reg(input logic [31:0] off, input logic [31:0] v);
    exp_q.push_back({DEV_REG_BASE + off, v});
  endtask

  task automatic push_sd(input logic [2:0] m, input logic [1:0] bk);
    exp_q.push_back({(e_base & ~(32'h3 << e_lsb)) | (32'(bk) << e_lsb), 32'h0});
    exp_cmd.push_back(m * 4 + bk);
  endtask

  // ------------------------------------------
  // one full bring-up against the reference list
  // ------------------------------------------
  task automatic bring_up(input logic mob, input logic r8k, input logic [1:0] cs);
    logic [31:0] cfg, lp, mdev, tr, d, q;
    logic [1:0]  bb;
    int n0, c0, i;
    cfg = rnd();
    lp = rnd();
    mdev = rnd();
    tr = rnd();
    e_base = rnd() | 32'h8000_0000;
    e_lsb = 9 + cs + (r8k ? 13 : 12);
    bb = 2'(e_base >> e_lsb);
    geom <= '{mob, r8k, cs};
    exp_q.delete();
    exp_cmd.delete();
    push_reg(DEV_OFF_CFG, cfg);
    if (mob) push_reg(DEV_OFF_LP, lp);
    push_reg(DEV_OFF_MDEV, mdev);
    push_reg(DEV_OFF_MODE, 32'(MODE_NOP));
    push_sd(MODE_NOP, bb);
    push_reg(DEV_OFF_MODE, 32'(MODE_PRECH));
    push_sd(MODE_PRECH, bb);
    push_reg(DEV_OFF_MODE, 32'(MODE_REFRESH));
    for (i = 0; i < 8; i++) push_sd(MODE_REFRESH, bb);
    push_reg(DEV_OFF_MODE, 32'(MODE_MRS));
    push_sd(MODE_MRS, 2'h0);
    if (mob) push_reg(DEV_OFF_MODE, 32'(MODE_EMRS));
    if (mob) push_sd(MODE_EMRS, 2'h1);
    push_reg(DEV_OFF_MODE, 32'(MODE_NORMAL));
    push_sd(MODE_NORMAL, bb);
    push_reg(DEV_OFF_TR, tr);
    n0 = dev.log_q.size();
    c0 = dev.cmd_q.size();
    wr_ok(IDX_CFG, cfg);
    wr_ok(IDX_LP, lp);
    wr_ok(IDX_MDEV, mdev);
    wr_ok(IDX_TR, tr);
    wr_ok(IDX_BASE, e_base);
    d = {26'h0, cs, 1'b0, r8k, mob, 1'b1};
    wr_ok(IDX_CTRL, d);
    rd_reg(IDX_CTRL, q);
    check(q, d & ~32'h1, "ctrl");
    rd_reg(IDX_STAT, q);
    check(q[1:0], 2'h1, "busy");
    for (i = 0; i < 3000 && q[1] !== 1'b1; i++) rd_reg(IDX_STAT, q);
    check(q[1:0], 2'h2, "done");
    check(dev.log_q.size() - n0, exp_q.size(), "write count");
    check(dev.cmd_q.size() - c0, exp_cmd.size(), "cmd count");
    check(dev.tr_ff, tr[11:0], "timer count");
    foreach (exp_q[k]) if (n0 + k < dev.log_q.size()) check(dev.log_q[n0 + k], exp_q[k], "write");
    foreach (exp_cmd[k]) if (c0 + k < dev.cmd_q.size()) check(dev.cmd_q[c0 + k], exp_cmd[k], "cmd");
    i = mob ? 2 : 1;
    if (dev.t_q.size() > n0 + i + 1) check(dev.t_q[n0 + i + 1] - dev.t_q[n0 + i] >= 4000, 1, "pause");
  endtask

  // ------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------
  initial begin
    logic [31:0] v, q;
    logic [1:0]  r;
    int          i;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 7; i++) begin
      rd_reg(3'(i), q);
      check(q, RST_WORD, "reset value");
    end
    for (i = 2; i < 7; i++) begin
      v = rnd();
      wr_ok(3'(i), v);
      rd_reg(3'(i), q);
      check(q, v, "readback");
    end
    v = rnd();
    wr_ok(IDX_CFG, v);
    axi_wr({3'h0, IDX_CFG, 2'h0}, ~v, 4'h3, r);
    axi_wr(8'h1c, 32'hffff_ffff, 4'hf, r);
    check(r, RESP_SLVERR, "unmapped");
    axi_wr(8'h24, 32'hffff_ffff, 4'hf, r);
    check(r, RESP_SLVERR, "unmapped");
    axi_rd(8'h1c, q, r);
    check(r, RESP_SLVERR, "unmapped rd");
    check(q, RST_WORD, "unmapped rd data");
    wr_ok(IDX_STAT, 32'hffff_ffff);
    rd_reg(IDX_STAT, q);
    check(q, RST_WORD, "stat ro");
    rd_reg(IDX_CFG, q);
    check(q, {v[31:16], ~v[15:0]}, "strobe merge");
    stall_en <= 1'b1;
    bring_up(1'b0, 1'b0, 2'(rnd()));
    bring_up(1'b1, 1'b1, 2'(rnd()));
    check(dev.bad, 0, "held request");
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
endmodule
